// [common/irq_cfg.svh]
// offsets, field positions, reset values and timing of the interrupt and event transfer block
`ifndef IRQ_CFG_SVH
`define IRQ_CFG_SVH

// ************************************************************
// source population
// ************************************************************
`define NUM_CAPCOM 32
`define NUM_XNODE 3
`define NUM_SRC 36
`define NUM_CHAN 8
`define NUM_FAST 8
`define SRC_TIMER0 32
`define CC_MID_FIRST 16
`define CC_HI_FIRST 29
`define SRC_XNODE_FIRST 33

// ************************************************************
// trap number bases
// ************************************************************
`define TRAP_CC_LO 7'h10
`define TRAP_CC_MID 7'h30
`define TRAP_CC_HI 7'h44
`define TRAP_T0 7'h20
`define TRAP_XNODE 7'h40

// ************************************************************
// register map
// ************************************************************
`define OFF_CHAN_BASE 12'h100
`define OFF_EDGE_MODE 12'h180
`define OFF_STATUS 12'h200
`define SUB_CHAN_CTL 2'h0
`define SUB_CHAN_SRC 2'h1
`define SUB_CHAN_DST 2'h2

// source control word fields
`define CTRL_LVL_LSB 0
`define CTRL_CH_LSB 4
`define CTRL_PEC_BIT 7
`define CTRL_EN_BIT 8
`define CTRL_REQ_BIT 9

// channel control word fields
`define CH_CNT_LSB 0
`define CH_CONT_BIT 8
`define CH_WORD_BIT 9
`define CH_DST_BIT 10

// reset values
`define CTRL_RST 9'h000
`define CHAN_CTL_RST 11'h000
`define PTR_RST 24'h000000
`define EDGE_RST 16'h0000

// bus answers
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

// ************************************************************
// timing
// ************************************************************
`define CLK_PERIOD_NS 5
`define RESP_MIN_NS 250
`define RESP_MAX_NS 600
`define RESP_MIN_CYC ((`RESP_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESP_MAX_CYC (`RESP_MAX_NS / `CLK_PERIOD_NS)

`endif

// [common/irq_pkg.sv]
// types shared by the interrupt and event transfer block
package irq_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DELAY = 2'b01,
        ST_OFFER = 2'b10
    } resp_state_t;

    typedef logic [3:0] level_t;
    typedef logic [6:0] trap_t;
    typedef logic [23:0] ptr_t;

endpackage

// [rtl/edge_detect.sv]
// programmable edge detector for the fast external interrupt pins
`timescale 1ns/100ps
module edge_detect #(
    parameter int N = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // pins and edge selection
    input wire logic [N-1:0] pin,
    input wire logic [N-1:0] mode_rise,
    input wire logic [N-1:0] mode_fall,
    // one-cycle edge events
    output logic [N-1:0] evt
);

    logic [N-1:0] prev_ff;
    logic armed_ff;

    // armed one clock after reset so a pin high out of reset is not taken as a rise
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prev_ff <= '0;
            armed_ff <= 1'b0;
            evt <= '0;
        end else begin
            prev_ff <= pin;
            armed_ff <= 1'b1;
            evt <= {N{armed_ff}} & ((pin & ~prev_ff & mode_rise)
                                   | (~pin & prev_ff & mode_fall));
        end
    end

endmodule

// [rtl/prio_arbiter.sv]
// picks the enabled request with the highest level above the cpu level
`timescale 1ns/100ps
module prio_arbiter import irq_pkg::*; #(
    parameter int N = 36,
    parameter int IW = 6
) (
    // candidates
    input wire logic [N-1:0] cand,
    input wire logic [4*N-1:0] lvl_flat,
    input wire level_t floor_lvl,
    // winner
    output logic win_valid,
    output logic [IW-1:0] win_idx,
    output level_t win_lvl
);

    // strict compare: equal levels keep the lowest index
    always_comb begin
        win_valid = 1'b0;
        win_idx = '0;
        win_lvl = floor_lvl;
        for (int i = 0; i < N; i++) begin
            if (cand[i] && (lvl_flat[4*i+:4] > win_lvl)) begin
                win_valid = 1'b1;
                win_idx = IW'(i);
                win_lvl = lvl_flat[4*i+:4];
            end
        end
    end

endmodule

// [rtl/irq_event_ctrl.sv]
// interrupt controller with eight-channel single-cycle event transfer unit
//
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
`include "irq_cfg.svh"
module irq_event_ctrl import irq_pkg::*; #(
    parameter int NSRC = `NUM_SRC,
    parameter int NCH = `NUM_CHAN,
    parameter int NFAST = `NUM_FAST,
    parameter int AW = 12
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // axi4-lite write address
    input wire logic [AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    // axi4-lite write data
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // request sources
    input wire logic [`NUM_CAPCOM-1:0] capcom_event,
    input wire logic timer0_event,
    input wire logic [`NUM_XNODE-1:0] xnode_event,
    input wire logic [NFAST-1:0] fast_pin,
    // cpu core side
    input wire level_t cpu_prio,
    input wire logic int_ack,
    input wire logic sw_trap_valid,
    input wire trap_t sw_trap_num,
    output logic int_req,
    output logic [8:0] int_vector,
    output trap_t int_trap,
    output level_t int_level,
    // event transfer to the core's memory path
    output logic xfer_req,
    output ptr_t xfer_src,
    output ptr_t xfer_dst,
    output logic xfer_word,
    output logic [2:0] xfer_chan
);

    localparam int IW = 6;

    // ************************************************************
    // state
    // ************************************************************
    logic [8:0] cfg_ff [NSRC];
    logic [NSRC-1:0] req_ff;
    logic [NSRC-1:0] nxt_req;
    logic [10:0] chan_ctl_ff [NCH];
    ptr_t src_ptr_ff [NCH];
    ptr_t dst_ptr_ff [NCH];
    logic [15:0] edge_mode_ff;
    resp_state_t state_ff;
    logic [IW-1:0] idx_ff;
    trap_t trap_ff;
    level_t lvl_ff;
    logic own_sw_ff;
    logic [6:0] dly_ff;
    logic sw_pend_ff;
    trap_t sw_num_ff;

    // bus side
    logic aw_have_ff;
    logic w_have_ff;
    logic [AW-1:0] wr_addr_ff;
    logic [31:0] wr_data_ff;
    logic [3:0] wr_strb_ff;

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b+:8] = new_v[8*b+:8];
            end
        end
        return r;
    endfunction

    function automatic logic is_src(input logic [AW-1:0] a);
        return (a[AW-1:8] == '0) && (a[7:2] < IW'(NSRC)) && (a[1:0] == 2'b00);
    endfunction

    function automatic logic is_chan(input logic [AW-1:0] a);
        return (a[AW-1:7] == `OFF_CHAN_BASE >> 7) && (a[3:2] != 2'h3) && (a[1:0] == 2'b00);
    endfunction

    function automatic logic map_hit(input logic [AW-1:0] a);
        return is_src(a) || is_chan(a) || (a == `OFF_EDGE_MODE) || (a == `OFF_STATUS);
    endfunction

    // trap number of a hardware source
    function automatic trap_t trap_of(input logic [IW-1:0] idx);
        if (idx < IW'(`CC_MID_FIRST)) begin
            return trap_t'(`TRAP_CC_LO + {1'b0, idx});
        end else if (idx < IW'(`CC_HI_FIRST)) begin
            return trap_t'(`TRAP_CC_MID + {1'b0, idx} - 7'(`CC_MID_FIRST));
        end else if (idx < IW'(`SRC_TIMER0)) begin
            return trap_t'(`TRAP_CC_HI + {1'b0, idx} - 7'(`CC_HI_FIRST));
        end else if (idx == IW'(`SRC_TIMER0)) begin
            return `TRAP_T0;
        end else begin
            return trap_t'(`TRAP_XNODE + {1'b0, idx} - 7'(`SRC_XNODE_FIRST));
        end
    endfunction

    // register contents as seen from the bus
    function automatic logic [31:0] reg_word(input logic [AW-1:0] a);
        logic [2:0] c;
        c = a[6:4];
        if (is_src(a)) begin
            return {22'h0, req_ff[a[7:2]], cfg_ff[a[7:2]]};
        end else if (is_chan(a)) begin
            case (a[3:2])
                `SUB_CHAN_CTL: return {21'h0, chan_ctl_ff[c]};
                `SUB_CHAN_SRC: return {8'h0, src_ptr_ff[c]};
                default: return {8'h0, dst_ptr_ff[c]};
            endcase
        end else if (a == `OFF_EDGE_MODE) begin
            return {16'h0, edge_mode_ff};
        end else if (a == `OFF_STATUS) begin
            return {9'h0, trap_ff, 2'b00, idx_ff, 6'h0, 2'(state_ff)};
        end else begin
            return 32'h0;
        end
    endfunction

    // ************************************************************
    // request sources
    // ************************************************************
    logic [NFAST-1:0] fast_evt;
    logic [NSRC-1:0] hw_evt;

    edge_detect #(
        .N(NFAST)
    ) i_edge_detect (
        .clk_sys(clk_sys),
        .rst(rst),
        .pin(fast_pin),
        .mode_rise(edge_mode_ff[7:0]),
        .mode_fall(edge_mode_ff[15:8]),
        .evt(fast_evt)
    );

    // fast pins share the nodes of capcom sources 8 to 15
    assign hw_evt = {xnode_event, timer0_event, capcom_event | {16'h0, fast_evt, 8'h00}};

    // ************************************************************
    // arbitration
    // ************************************************************
    logic [NSRC-1:0] cand;
    logic [4*NSRC-1:0] lvl_flat;
    logic win_valid;
    logic [IW-1:0] win_idx;
    level_t win_lvl;

    always_comb begin
        for (int i = 0; i < NSRC; i++) begin
            cand[i] = req_ff[i] & cfg_ff[i][`CTRL_EN_BIT];
            lvl_flat[4*i+:4] = cfg_ff[i][`CTRL_LVL_LSB+:4];
        end
    end

    prio_arbiter #(
        .N(NSRC),
        .IW(IW)
    ) i_prio_arbiter (
        .cand(cand),
        .lvl_flat(lvl_flat),
        .floor_lvl(cpu_prio),
        .win_valid(win_valid),
        .win_idx(win_idx),
        .win_lvl(win_lvl)
    );

    // ************************************************************
    // service decision
    // ************************************************************
    logic [2:0] win_ch;
    logic win_pec;
    logic ch_cont;
    logic ch_live;
    logic ch_last;
    logic take;
    logic pec_fire;
    logic std_take;
    logic svc_clr;
    logic [IW-1:0] svc_idx;

    always_comb begin
        win_ch = cfg_ff[win_idx][`CTRL_CH_LSB+:3];
        win_pec = cfg_ff[win_idx][`CTRL_PEC_BIT];
        ch_cont = chan_ctl_ff[win_ch][`CH_CONT_BIT];
        ch_live = ch_cont || (chan_ctl_ff[win_ch][`CH_CNT_LSB+:8] != 8'h00);
        ch_last = !ch_cont && (chan_ctl_ff[win_ch][`CH_CNT_LSB+:8] == 8'h01);
        take = (state_ff == ST_IDLE) && win_valid && !sw_pend_ff;
        pec_fire = take && win_pec && ch_live;
        // an exhausted channel falls back to the source's own vector
        std_take = take && !(win_pec && ch_live);
        // last transfer leaves the flag set so the vectored service follows
        svc_clr = (pec_fire && !ch_last)
                  || ((state_ff == ST_OFFER) && int_ack && !own_sw_ff);
        svc_idx = pec_fire ? win_idx : idx_ff;
    end

    // ************************************************************
    // register writes
    // ************************************************************
    logic wr_go;
    logic [31:0] wr_merged;

    assign wr_go = aw_have_ff && w_have_ff && !bvalid;
    // a process, so register reads inside the helper stay in the sensitivity
    always_comb wr_merged = merge_strb(reg_word(wr_addr_ff), wr_data_ff, wr_strb_ff);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int i = 0; i < NSRC; i++) begin
                cfg_ff[i] <= `CTRL_RST;
            end
            edge_mode_ff <= `EDGE_RST;
        end else if (wr_go) begin
            if (is_src(wr_addr_ff)) begin
                cfg_ff[wr_addr_ff[7:2]] <= wr_merged[8:0];
            end
            if (wr_addr_ff == `OFF_EDGE_MODE) begin
                edge_mode_ff <= wr_merged[15:0];
            end
        end
    end

    // set beats any clear arriving in the same cycle
    always_comb begin
        logic set_b;
        logic clr_b;
        set_b = 1'b0;
        clr_b = 1'b0;
        nxt_req = req_ff;
        for (int i = 0; i < NSRC; i++) begin
            set_b = hw_evt[i];
            clr_b = 1'b0;
            if (wr_go && is_src(wr_addr_ff) && (wr_addr_ff[7:2] == IW'(i))) begin
                if (wr_merged[`CTRL_REQ_BIT]) begin
                    set_b = 1'b1;
                end else begin
                    clr_b = 1'b1;
                end
            end
            if (svc_clr && (svc_idx == IW'(i))) begin
                clr_b = 1'b1;
            end
            nxt_req[i] = set_b | (req_ff[i] & ~clr_b);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            req_ff <= '0;
        end else begin
            req_ff <= nxt_req;
        end
    end

    // ************************************************************
    // transfer channels
    // ************************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int c = 0; c < NCH; c++) begin
                chan_ctl_ff[c] <= `CHAN_CTL_RST;
                src_ptr_ff[c] <= `PTR_RST;
                dst_ptr_ff[c] <= `PTR_RST;
            end
        end else begin
            if (wr_go && is_chan(wr_addr_ff)) begin
                case (wr_addr_ff[3:2])
                    `SUB_CHAN_CTL: chan_ctl_ff[wr_addr_ff[6:4]] <= wr_merged[10:0];
                    `SUB_CHAN_SRC: src_ptr_ff[wr_addr_ff[6:4]] <= wr_merged[23:0];
                    default: dst_ptr_ff[wr_addr_ff[6:4]] <= wr_merged[23:0];
                endcase
            end
            // the transfer's own update wins over a same-cycle bus write
            if (pec_fire) begin
                if (!ch_cont) begin
                    chan_ctl_ff[win_ch][`CH_CNT_LSB+:8] <=
                        chan_ctl_ff[win_ch][`CH_CNT_LSB+:8] - 8'h01;
                end
                if (chan_ctl_ff[win_ch][`CH_DST_BIT]) begin
                    dst_ptr_ff[win_ch] <= dst_ptr_ff[win_ch]
                        + (chan_ctl_ff[win_ch][`CH_WORD_BIT] ? 24'h2 : 24'h1);
                end else begin
                    src_ptr_ff[win_ch] <= src_ptr_ff[win_ch]
                        + (chan_ctl_ff[win_ch][`CH_WORD_BIT] ? 24'h2 : 24'h1);
                end
            end
        end
    end

    // single-cycle move strobe carrying the pre-increment pointers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            xfer_req <= 1'b0;
            xfer_src <= `PTR_RST;
            xfer_dst <= `PTR_RST;
            xfer_word <= 1'b0;
            xfer_chan <= 3'h0;
        end else begin
            xfer_req <= pec_fire;
            if (pec_fire) begin
                xfer_src <= src_ptr_ff[win_ch];
                xfer_dst <= dst_ptr_ff[win_ch];
                xfer_word <= chan_ctl_ff[win_ch][`CH_WORD_BIT];
                xfer_chan <= win_ch;
            end
        end
    end

    // ************************************************************
    // software trap capture
    // ************************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sw_pend_ff <= 1'b0;
            sw_num_ff <= 7'h00;
        end else if (sw_trap_valid) begin
            sw_pend_ff <= 1'b1;
            sw_num_ff <= sw_trap_num;
        end else if (state_ff == ST_IDLE) begin
            sw_pend_ff <= 1'b0;
        end
    end

    // ************************************************************
    // vectored response
    // ************************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_ff <= ST_IDLE;
            idx_ff <= '0;
            trap_ff <= 7'h00;
            lvl_ff <= 4'h0;
            own_sw_ff <= 1'b0;
            dly_ff <= 7'h00;
            int_req <= 1'b0;
            int_vector <= 9'h000;
            int_trap <= 7'h00;
            int_level <= 4'h0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    dly_ff <= 7'(`RESP_MIN_CYC - 2);
                    if (sw_pend_ff) begin
                        // a trap runs at the current cpu level
                        trap_ff <= sw_num_ff;
                        lvl_ff <= cpu_prio;
                        own_sw_ff <= 1'b1;
                        state_ff <= ST_DELAY;
                    end else if (std_take) begin
                        idx_ff <= win_idx;
                        trap_ff <= trap_of(win_idx);
                        lvl_ff <= win_lvl;
                        own_sw_ff <= 1'b0;
                        state_ff <= ST_DELAY;
                    end
                end
                ST_DELAY: begin
                    if (dly_ff == 7'h00) begin
                        int_req <= 1'b1;
                        int_vector <= {trap_ff, 2'b00};
                        int_trap <= trap_ff;
                        int_level <= lvl_ff;
                        state_ff <= ST_OFFER;
                    end else begin
                        dly_ff <= dly_ff - 7'h01;
                    end
                end
                ST_OFFER: begin
                    if (int_ack) begin
                        int_req <= 1'b0;
                        state_ff <= ST_IDLE;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // axi4-lite write channel
    // ************************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            awready <= 1'b1;
            wready <= 1'b1;
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
            wr_addr_ff <= '0;
            wr_data_ff <= 32'h0;
            wr_strb_ff <= 4'h0;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_have_ff <= 1'b1;
                awready <= 1'b0;
                wr_addr_ff <= awaddr;
            end
            if (wvalid && wready) begin
                w_have_ff <= 1'b1;
                wready <= 1'b0;
                wr_data_ff <= wdata;
                wr_strb_ff <= wstrb;
            end
            if (wr_go) begin
                aw_have_ff <= 1'b0;
                w_have_ff <= 1'b0;
                bvalid <= 1'b1;
                bresp <= map_hit(wr_addr_ff) ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // ************************************************************
    // axi4-lite read channel
    // ************************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= `RESP_OKAY;
        end else begin
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                rdata <= reg_word(araddr);
                rresp <= map_hit(araddr) ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (rvalid && rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

endmodule

// [testbench/irq_event_ctrl_props.sv]
// port checks for the interrupt and event transfer block
`timescale 1ns/100ps
module irq_event_ctrl_props import irq_pkg::*; (
    input wire logic clk_sys, rst, int_req, int_ack, xfer_req,
    input wire logic awready, wready, bvalid, arready, rvalid, rready,
    input wire logic [8:0] int_vector,
    input wire trap_t int_trap,
    input wire ptr_t xfer_src
);
    localparam int LOW_MIN = 49;
    logic [7:0] low_ff;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // saturating idle run of the offer line
    always_ff @(posedge clk_sys) begin
        if (rst || int_req) low_ff <= 8'h00;
        else if (low_ff != 8'hFF) low_ff <= low_ff + 8'h01;
    end
    a_offer_holds: assert property (int_req && !int_ack |=> int_req && $stable(int_trap))
        else $error("offer lost");
    a_ack_clears: assert property (int_req && int_ack |=> !int_req)
        else $error("offer kept");
    a_vector_trap: assert property (int_req |-> int_vector == {int_trap, 2'b00})
        else $error("vector mismatch");
    a_resp_floor: assert property ($rose(int_req) |-> low_ff >= 8'(LOW_MIN))
        else $error("offer too early");
    a_ptr_moves: assert property ($changed(xfer_src) |-> xfer_req)
        else $error("pointer moved");
    a_wr_busy: assert property (bvalid |-> !awready && !wready)
        else $error("write overlap");
    a_rd_busy: assert property (rvalid |-> !arready)
        else $error("read overlap");
    a_rd_answer: assert property (rvalid && rready |=> !rvalid)
        else $error("read kept");
endmodule

// [testbench/cpu_model.sv]
// cpu core stand-in: accepts an offered interrupt after a lag
`timescale 1ns/100ps
module cpu_model (
    input wire logic clk_sys, rst, int_req,
    input wire logic [3:0] lag,
    output logic int_ack
);
    logic [3:0] wait_ff;
    always_ff @(posedge clk_sys) begin
        if (rst || !int_req || int_ack) {wait_ff, int_ack} <= 5'h00;
        else if (wait_ff == lag) int_ack <= 1'b1;
        else wait_ff <= wait_ff + 4'h1;
    end
endmodule

// [testbench/interrupt_and_event_transfer_tb_top.sv]
// bench for the interrupt and event transfer block
`timescale 1ns/100ps
module interrupt_and_event_transfer_tb_top;
    logic clk_sys = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic sw_trap_valid = 0, timer0_event = 0, awready, wready, bvalid, arready, rvalid;
    logic int_req, int_ack, xfer_req, xfer_word;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, capcom_event = 0, rdata, d;
    logic [3:0] cpu_prio = 0, lag = 0, wstrb = 4'hF, int_level;
    logic [1:0] bresp, rresp, r;
    logic [2:0] xnode_event = 0, xfer_chan;
    logic [7:0] fast_pin = 0;
    logic [6:0] sw_trap_num = 0, int_trap, tv[8] = '{'h10, 'h1F, 'h30, 'h3C, 'h44, 'h46, 'h20, 'h41};
    logic [8:0] int_vector;
    logic [23:0] xfer_src, xfer_dst;
    int bad_count = 0, samples_checked = 0, n, sv[8] = '{0, 15, 16, 28, 29, 31, 32, 34};
    irq_event_ctrl i_irq_event_ctrl (.clk_sys, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .capcom_event, .timer0_event, .xnode_event, .fast_pin, .cpu_prio,
        .int_ack, .sw_trap_valid, .sw_trap_num, .int_req, .int_vector, .int_trap, .int_level,
        .xfer_req, .xfer_src, .xfer_dst, .xfer_word, .xfer_chan);
    cpu_model i_cpu_model (.clk_sys, .rst, .int_req, .lag, .int_ack);
    initial forever #2.5 clk_sys = ~clk_sys;
    task automatic print_verdict;
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    // a used-up wait bound ends the run
    task automatic tmo(input int lim);
        if (n < lim) return;
        bad_count++;
        print_verdict();
    endtask
    // one bus transfer: write when w, else read into d; response code into r
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        {awaddr, araddr, wdata} <= {a, a, v};
        {awvalid, wvalid, bready, arvalid, rready} <= {w, w, w, !w, !w};
        for (n = 0; n < 50; n++) begin
            @(posedge clk_sys);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (arready) arvalid <= 1'b0;
            if (bvalid || rvalid) break;
        end
        tmo(50);
        {d, r} = {rdata, w ? bresp : rresp};
        {bready, rready} <= 2'h0;
    endtask
    task automatic wait_irq(input logic [6:0] t);
        for (n = 0; n < 130 && int_req !== 1'b1; n++) begin
            @(posedge clk_sys);
            #1;
        end
        tmo(121);
        chk("early", 32'h0, {31'h0, n < 49});
        chk("trap", t, int_trap);
        chk("vector", {t, 2'b00}, int_vector);
        for (n = 0; n < 20 && int_req; n++) @(posedge clk_sys);
        tmo(20);
    endtask
    task automatic quiet;
        repeat (60) @(posedge clk_sys);
        chk("no offer", 32'h0, {31'h0, int_req});
    endtask
    task automatic pulse(input logic [31:0] m);
        @(posedge clk_sys);
        capcom_event <= m;
        @(posedge clk_sys);
        capcom_event <= 32'h0;
    endtask
    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        acc(0, 12'h000, 0);
        chk("ctrl reset", 32'h0, d);
        acc(0, 12'h300, 0);
        chk("unmapped", 32'h2, {30'h0, r});
        acc(1, 12'h300, 32'h0000_0001);
        chk("wr unmapped", 32'h2, {30'h0, r});
        for (int i = 0; i < 8; i++) begin
            acc(1, 12'(sv[i] * 4), 32'h0000_030F);
            chk("wr okay", 32'h0, {30'h0, r});
            wait_irq(tv[i]);
            acc(0, 12'(sv[i] * 4), 0);
            chk("flag", 32'h0000_010F, d);
        end
        cpu_prio <= 4'h3;
        acc(1, 12'h004, 32'h0000_0104);
        acc(1, 12'h008, 32'h0000_0107);
        acc(1, 12'h00C, 32'h0000_0103);
        pulse(32'h0000_000E);
        wait_irq(7'h12);
        chk("level", 32'h7, {28'h0, int_level});
        wait_irq(7'h11);
        quiet();
        cpu_prio <= 4'h0;
        wait_irq(7'h13);
        lag <= 4'h7;
        sw_trap_num <= 7'h55;
        sw_trap_valid <= 1'b1;
        @(posedge clk_sys);
        sw_trap_valid <= 1'b0;
        wait_irq(7'h55);
        chk("trap level", 32'h0, {28'h0, int_level});
        acc(1, 12'h180, 32'h0000_0100);
        acc(1, 12'h020, 32'h0000_0102);
        fast_pin <= 8'h01;
        quiet();
        fast_pin <= 8'h00;
        wait_irq(7'h18);
        acc(1, 12'h120, 32'h0000_0202);
        acc(1, 12'h124, 32'h0000_1000);
        acc(1, 12'h128, 32'h0000_2000);
        acc(1, 12'h010, 32'h0000_01A6);
        for (int k = 0; k < 2; k++) begin
            pulse(32'h0000_0010);
            @(posedge clk_sys);
            #1;
            chk("xfer", 32'h1, {31'h0, xfer_req});
            chk("src", 32'h1000 + 2 * k, {8'h0, xfer_src});
            chk("dst kind", 32'h2000_5, {xfer_dst, xfer_chan, xfer_word});
        end
        wait_irq(7'h14);
        acc(0, 12'h120, 0);
        chk("count", 32'h0000_0200, d);
        acc(1, 12'h120, 32'h0000_0500);
        pulse(32'h0000_0010);
        @(posedge clk_sys);
        #1;
        chk("dst xfer", 32'h2000_4, {xfer_dst, xfer_chan, xfer_word});
        acc(0, 12'h120, 0);
        chk("cont count", 32'h0000_0500, d);
        acc(0, 12'h128, 0);
        chk("dst bump", 32'h0000_2001, d);
        acc(0, 12'h010, 0);
        chk("xfer flag", 32'h0000_01A6, d);
        print_verdict();
    end
endmodule
bind irq_event_ctrl irq_event_ctrl_props i_irq_event_ctrl_props (.clk_sys, .rst, .int_req,
    .int_ack, .xfer_req, .awready, .wready, .bvalid, .arready, .rvalid, .rready, .int_vector,
    .int_trap, .xfer_src);
